/* lcd_dec_pkg.sv */
// Constants, types and decoders for the character display instruction decoder.
// Assumes one 100 MHz clock and an APB master holding each request until answered.
package lcd_dec_pkg;

	localparam int ADDR_W    = 7;
	localparam int DATA_W    = 8;
	localparam int RAM_DEPTH = 128;
	localparam int APB_AW    = 8;
	localparam int APB_DW    = 32;

	localparam logic [APB_AW-1:0] OFS_INSTR = 8'h00;
	localparam logic [APB_AW-1:0] OFS_DATA  = 8'h04;
	localparam logic [APB_AW-1:0] OFS_STATE = 8'h08;

	localparam int CLK_PERIOD_NS = 10;
	localparam int INIT_BUSY_NS  = 2000000;
	localparam int INIT_BUSY_CYC = (INIT_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_CYC     = 165;
	localparam int EXEC_CYC      = 3;

	localparam logic [DATA_W-1:0] SPACE_CODE = 8'h20;
	localparam logic [ADDR_W-1:0] HOME_ADDR  = 7'h00;

	// Instruction field positions
	localparam int BIT_BUSY   = 7;
	localparam int ENT_DIR    = 1;
	localparam int ENT_SHIFT  = 0;
	localparam int DC_DISP    = 2;
	localparam int DC_CURSOR  = 1;
	localparam int DC_BLINK   = 0;
	localparam int SH_DISPLAY = 3;
	localparam int SH_RIGHT   = 2;
	localparam int FS_WIDTH   = 4;
	localparam int FS_LINES   = 3;
	localparam int FS_LAYOUT  = 2;
	localparam int FS_VGEN    = 1;
	localparam int GLYPH_AW   = 6;

	// State word layout
	localparam int ST_BLINK   = 0;
	localparam int ST_CURSOR  = 1;
	localparam int ST_DISP    = 2;
	localparam int ST_DIR     = 3;
	localparam int ST_SHIFT   = 4;
	localparam int ST_VGEN    = 5;
	localparam int ST_WIDTH   = 6;
	localparam int ST_FMT_LSB = 7;
	localparam int ST_GLYPH   = 9;
	localparam int ST_BUSY    = 10;
	localparam int ST_OFS_LSB = 16;

	// Reset values
	localparam logic RST_WIDTH = 1'b1;
	localparam logic RST_DIR   = 1'b1;
	localparam logic RST_OFF   = 1'b0;

	typedef enum logic [3:0] {
		K_NOP        = 4'b0000,
		K_CLEAR      = 4'b0001,
		K_HOME       = 4'b0010,
		K_ENTRY      = 4'b0011,
		K_DISPCTL    = 4'b0100,
		K_SHIFT      = 4'b0101,
		K_FUNC       = 4'b0110,
		K_GLYPH_ADDR = 4'b0111,
		K_TEXT_ADDR  = 4'b1000
	} instr_kind_t;

	typedef enum logic [1:0] {
		FMT_2X12 = 2'b00,
		FMT_2X24 = 2'b01,
		FMT_4X12 = 2'b10
	} line_fmt_t;

	function automatic instr_kind_t decode_instr(input logic [DATA_W-1:0] code);
		priority casez (code)
			8'b1???????: decode_instr = K_TEXT_ADDR;
			8'b01??????: decode_instr = K_GLYPH_ADDR;
			8'b001?????: decode_instr = K_FUNC;
			8'b0001????: decode_instr = K_SHIFT;
			8'b00001???: decode_instr = K_DISPCTL;
			8'b000001??: decode_instr = K_ENTRY;
			8'b0000001?: decode_instr = K_HOME;
			8'b00000001: decode_instr = K_CLEAR;
			default:     decode_instr = K_NOP;
		endcase
	endfunction

	function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
	                                                 input logic up);
		step_addr = up ? ADDR_W'(a + 1'b1) : ADDR_W'(a - 1'b1);
	endfunction

endpackage

/* lcd_host_model.sv */
// Host microcontroller model: APB master for the display instruction decoder.
// Assumes the bench calls its tasks from one process on the rising clock edge.
module lcd_host_model
	import lcd_dec_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              pready_i,
	input  wire logic              pslverr_i,
	input  wire logic [APB_DW-1:0] prdata_i,
	output logic                   psel_o,
	output logic                   penable_o,
	output logic                   pwrite_o,
	output logic      [APB_AW-1:0] paddr_o,
	output logic      [APB_DW-1:0] pwdata_o
);
	int n_hang = 0;

	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = '0;
		pwdata_o = '0;
	end

	// One transfer to the register at adr, any offset; an edge always passes first
	task automatic xfer(input logic wr, input logic [APB_AW-1:0] adr,
	                    input logic [APB_DW-1:0] wd, output logic [APB_DW-1:0] rd,
	                    output logic err);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= wr;
		paddr_o <= adr;
		pwdata_o <= wd;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 50);
		if (n >= 50)
			n_hang++;
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released data lines do not keep the old value
		pwdata_o <= ~wd;
	endtask

	// Poll the status word instead of trusting a fixed wait
	task automatic wait_idle();
		logic [APB_DW-1:0] s;
		logic              e;
		int                k;
		for (k = 0; k < 400; k++) begin
			xfer(1'b0, OFS_INSTR, '0, s, e);
			if (s[7] === 1'b0)
				break;
		end
		if (k == 400)
			n_hang++;
	endtask
endmodule

/* lcd_instr_decoder.sv */
// Instruction decoder, busy flag, address counter and display settings.
// Assumes an APB master on SYS_CLK_I; all host inputs are on this clock.
//
// The APB register port and the address map were left to the implementer.
module lcd_instr_decoder
	import lcd_dec_pkg::*;
#(
	parameter int INIT_BUSY_CYCLES = INIT_BUSY_CYC
) (
	input  wire logic              SYS_CLK_I,
	input  wire logic              NRST_I,
	input  wire logic              PSEL_I,
	input  wire logic              PENABLE_I,
	input  wire logic              PWRITE_I,
	input  wire logic [APB_AW-1:0] PADDR_I,
	input  wire logic [APB_DW-1:0] PWDATA_I,
	output logic      [APB_DW-1:0] PRDATA_O,
	output logic                   PREADY_O,
	output logic                   PSLVERR_O,
	output logic                   BUSY_O,
	output logic                   DISPLAY_ON_O,
	output logic                   CURSOR_ON_O,
	output logic                   BLINK_ON_O,
	output logic [1:0]             LINE_FMT_O,
	output logic                   BUS_WIDTH_SEL_O,
	output logic                   VGEN_O
);

	localparam int CNT_W = (INIT_BUSY_CYCLES > CLEAR_CYC) ? $clog2(INIT_BUSY_CYCLES + 1) : 8;

	logic [DATA_W-1:0] text_ram  [RAM_DEPTH];
	logic [DATA_W-1:0] glyph_ram [RAM_DEPTH];

	logic [CNT_W-1:0]  busy_count;
	logic              busy_flag;
	logic [ADDR_W-1:0] addr_counter;
	logic              glyph_sel;
	logic [ADDR_W-1:0] shift_ofs;
	logic              dir_up;
	logic              shift_on;
	line_fmt_t         line_fmt;
	logic              clr_active;
	logic [ADDR_W-1:0] clr_idx;
	logic              rd_go;

	logic              setup;
	logic              complete;
	logic              hit_instr;
	logic              hit_data;
	logic              hit_state;
	logic              wr_instr;
	logic              wr_data;
	logic              rd_data;
	logic [DATA_W-1:0] instruction_reg;
	logic [DATA_W-1:0] data_reg;
	instr_kind_t       kind;
	logic [DATA_W-1:0] ram_q;
	logic [APB_DW-1:0] state_word;
	logic [APB_DW-1:0] next_prdata;
	logic              start_exec;

	// Bus decode
	assign setup     = PSEL_I & ~PENABLE_I;
	assign complete  = PSEL_I & PENABLE_I & PREADY_O;
	assign hit_instr = (PADDR_I == OFS_INSTR);
	assign hit_data  = (PADDR_I == OFS_DATA);
	assign hit_state = (PADDR_I == OFS_STATE);

	// Instructions and data that land while busy are dropped
	assign instruction_reg = PWDATA_I[DATA_W-1:0];
	assign data_reg        = PWDATA_I[DATA_W-1:0];
	assign wr_instr        = complete & PWRITE_I & hit_instr & ~busy_flag;
	assign wr_data         = complete & PWRITE_I & hit_data & ~busy_flag;
	assign rd_data         = complete & ~PWRITE_I & rd_go;
	assign kind            = decode_instr(instruction_reg);

	// A no operation code neither changes state nor raises busy
	assign start_exec = (wr_instr & (kind != K_NOP)) | wr_data | rd_data;

	// One counter addresses both RAMs
	assign ram_q = glyph_sel ? glyph_ram[addr_counter] : text_ram[addr_counter];

	always_comb begin
		state_word                              = '0;
		state_word[ST_BLINK]                    = BLINK_ON_O;
		state_word[ST_CURSOR]                   = CURSOR_ON_O;
		state_word[ST_DISP]                     = DISPLAY_ON_O;
		state_word[ST_DIR]                      = dir_up;
		state_word[ST_SHIFT]                    = shift_on;
		state_word[ST_VGEN]                     = VGEN_O;
		state_word[ST_WIDTH]                    = BUS_WIDTH_SEL_O;
		state_word[ST_FMT_LSB +: 2]             = line_fmt;
		state_word[ST_GLYPH]                    = glyph_sel;
		state_word[ST_BUSY]                     = busy_flag;
		state_word[ST_OFS_LSB +: ADDR_W]        = shift_ofs;
	end

	always_comb begin
		next_prdata = '0;
		if (hit_instr) begin
			// Status read is answered at once, even while busy
			next_prdata[BIT_BUSY]     = busy_flag;
			next_prdata[ADDR_W-1:0]   = addr_counter;
		end else if (hit_data && !busy_flag) begin
			next_prdata[DATA_W-1:0] = ram_q;
		end else if (hit_state) begin
			next_prdata = state_word;
		end
	end

	// APB answer: one access cycle, no wait states
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= '0;
			rd_go     <= 1'b0;
		end else if (setup) begin
			PREADY_O  <= 1'b1;
			PSLVERR_O <= ~(hit_instr | hit_data | (hit_state & ~PWRITE_I));
			PRDATA_O  <= PWRITE_I ? '0 : next_prdata;
			rd_go     <= ~PWRITE_I & hit_data & ~busy_flag;
		end else if (complete) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			rd_go     <= 1'b0;
		end
	end

	// Busy timing; power-on starts a long busy phase on its own
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			busy_count <= CNT_W'(INIT_BUSY_CYCLES);
			busy_flag  <= 1'b1;
		end else if (start_exec) begin
			busy_flag  <= 1'b1;
			if (wr_instr && kind == K_CLEAR) begin
				busy_count <= CNT_W'(CLEAR_CYC);
			end else begin
				busy_count <= CNT_W'(EXEC_CYC);
			end
		end else if (busy_count > CNT_W'(1)) begin
			busy_count <= busy_count - 1'b1;
		end else begin
			busy_count <= '0;
			busy_flag  <= 1'b0;
		end
	end

	// Address counter and RAM select
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			addr_counter <= HOME_ADDR;
			glyph_sel    <= 1'b0;
		end else if (wr_instr) begin
			unique case (kind)
				K_CLEAR, K_HOME: begin
					addr_counter <= HOME_ADDR;
					glyph_sel    <= 1'b0;
				end
				K_TEXT_ADDR: begin
					addr_counter <= instruction_reg[ADDR_W-1:0];
					glyph_sel    <= 1'b0;
				end
				K_GLYPH_ADDR: begin
					// Top bit kept; only set via text address or stepping
					addr_counter <= {addr_counter[ADDR_W-1], instruction_reg[GLYPH_AW-1:0]};
					glyph_sel    <= 1'b1;
				end
				K_SHIFT: begin
					if (!instruction_reg[SH_DISPLAY]) begin
						addr_counter <= step_addr(addr_counter, instruction_reg[SH_RIGHT]);
					end
				end
				default: begin
				end
			endcase
		end else if (wr_data || rd_data) begin
			addr_counter <= step_addr(addr_counter, dir_up);
		end
	end

	// Display shift offset
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			shift_ofs <= '0;
		end else if (wr_instr && (kind == K_CLEAR || kind == K_HOME)) begin
			shift_ofs <= '0;
		end else if (wr_instr && kind == K_SHIFT && instruction_reg[SH_DISPLAY]) begin
			shift_ofs <= step_addr(shift_ofs, instruction_reg[SH_RIGHT]);
		end else if (wr_data && shift_on && !glyph_sel) begin
			// Incrementing entry shifts the picture left
			shift_ofs <= step_addr(shift_ofs, ~dir_up);
		end
	end

	// Entry mode
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			dir_up   <= RST_DIR;
			shift_on <= RST_OFF;
		end else if (wr_instr && kind == K_ENTRY) begin
			dir_up   <= instruction_reg[ENT_DIR];
			shift_on <= instruction_reg[ENT_SHIFT];
		end else if (wr_instr && kind == K_CLEAR) begin
			dir_up   <= 1'b1;
		end
	end

	// Display control
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			DISPLAY_ON_O <= RST_OFF;
			CURSOR_ON_O  <= RST_OFF;
			BLINK_ON_O   <= RST_OFF;
		end else if (wr_instr && kind == K_DISPCTL) begin
			DISPLAY_ON_O <= instruction_reg[DC_DISP];
			CURSOR_ON_O  <= instruction_reg[DC_CURSOR];
			BLINK_ON_O   <= instruction_reg[DC_BLINK];
		end
	end

	// Function set
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			BUS_WIDTH_SEL_O <= RST_WIDTH;
			VGEN_O          <= RST_OFF;
			line_fmt        <= FMT_2X12;
		end else if (wr_instr && kind == K_FUNC) begin
			BUS_WIDTH_SEL_O <= instruction_reg[FS_WIDTH];
			VGEN_O          <= instruction_reg[FS_VGEN];
			if (instruction_reg[FS_LINES] && !instruction_reg[FS_LAYOUT]) begin
				line_fmt <= FMT_2X24;
			end else if (instruction_reg[FS_LINES]) begin
				line_fmt <= FMT_4X12;
			end else if (!instruction_reg[FS_LAYOUT]) begin
				line_fmt <= FMT_2X12;
			end
			// Reserved layout keeps the old format
		end
	end

	assign LINE_FMT_O = line_fmt;
	assign BUSY_O     = busy_flag;

	// Clear sweep: one location per clock, well inside the busy time
	// A power-on busy time shorter than the sweep lets early text writes be lost
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			clr_active <= 1'b1;
			clr_idx    <= '0;
		end else if (wr_instr && kind == K_CLEAR) begin
			clr_active <= 1'b1;
			clr_idx    <= '0;
		end else if (clr_active) begin
			clr_idx    <= ADDR_W'(clr_idx + 1'b1);
			clr_active <= (clr_idx != ADDR_W'(RAM_DEPTH - 1));
		end
	end

	// RAM arrays carry no reset; the sweep blanks text after power-on
	always_ff @(posedge SYS_CLK_I) begin
		if (clr_active) begin
			text_ram[clr_idx] <= SPACE_CODE;
		end else if (wr_data && !glyph_sel) begin
			text_ram[addr_counter] <= data_reg;
		end
		if (wr_data && glyph_sel) begin
			glyph_ram[addr_counter] <= data_reg;
		end
	end

	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!NRST_I);

	chk_exec_three: assert property (
		wr_instr && kind == K_ENTRY |=> busy_flag [*3] ##1 !busy_flag
	) else $error("short instruction busy not three cycles");

	chk_clear_home: assert property (
		wr_instr && kind == K_CLEAR |=> addr_counter == HOME_ADDR && !glyph_sel
			&& busy_count == CNT_W'(CLEAR_CYC) && dir_up
	) else $error("clear did not home counter");

	chk_busy_ignore: assert property (
		busy_flag && complete && PWRITE_I && hit_instr |=> $stable(line_fmt)
			&& $stable(DISPLAY_ON_O) && $stable(shift_ofs)
	) else $error("instruction executed while busy");

	chk_data_step: assert property (
		wr_data |=> addr_counter == step_addr($past(addr_counter), $past(dir_up))
	) else $error("counter not stepped by one");

	chk_glyph_load: assert property (
		wr_instr && kind == K_GLYPH_ADDR |=> glyph_sel
			&& addr_counter[GLYPH_AW-1:0] == $past(instruction_reg[GLYPH_AW-1:0])
			&& addr_counter[ADDR_W-1] == $past(addr_counter[ADDR_W-1])
	) else $error("glyph address load wrong");

	chk_status_read: assert property (
		setup && !PWRITE_I && hit_instr |=> PREADY_O
			&& PRDATA_O[BIT_BUSY] == $past(busy_flag)
			&& PRDATA_O[ADDR_W-1:0] == $past(addr_counter)
	) else $error("status read wrong");

	chk_fmt_two24: assert property (
		wr_instr && kind == K_FUNC && instruction_reg[FS_LINES] && !instruction_reg[FS_LAYOUT]
			|=> line_fmt == FMT_2X24
	) else $error("two line format not set");

	chk_fmt_four12: assert property (
		wr_instr && kind == K_FUNC && instruction_reg[FS_LINES] && instruction_reg[FS_LAYOUT]
			|=> line_fmt == FMT_4X12
	) else $error("four line format not set");

	chk_nop_idle: assert property (
		wr_instr && kind == K_NOP |=> !busy_flag && $stable(addr_counter)
	) else $error("no operation changed state");

	chk_home_shift: assert property (
		wr_instr && kind == K_HOME |=> addr_counter == HOME_ADDR && shift_ofs == '0
			&& !glyph_sel && busy_flag
	) else $error("return home did not reset counter");

	chk_fmt_reserved: assert property (
		wr_instr && kind == K_FUNC && !instruction_reg[FS_LINES] && instruction_reg[FS_LAYOUT]
			|=> $stable(line_fmt)
	) else $error("reserved format changed the layout");

	chk_data_busy: assert property (
		wr_data |=> busy_flag [*3] ##1 !busy_flag
	) else $error("data access busy not three cycles");

	chk_busy_read: assert property (
		complete && !PWRITE_I && hit_data && !rd_go |=> $stable(addr_counter)
	) else $error("data read while busy moved the counter");

	chk_text_shift: assert property (
		wr_data && shift_on && !glyph_sel
			|=> shift_ofs == step_addr($past(shift_ofs), !$past(dir_up))
	) else $error("display did not shift with text write");

	chk_read_start: assert property (
		rd_data |=> busy_flag && busy_count == CNT_W'(EXEC_CYC)
	) else $error("data read did not start a busy phase");

endmodule

/* test_char_lcd_instruction_decoder.sv */
// Self-checking bench for the display instruction decoder.
// Assumes the host model drives APB; init busy is shortened to 20 cycles.
module test_char_lcd_instruction_decoder
	import lcd_dec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int INIT = 20;
	typedef struct packed {logic [7:0] code; logic [6:0] outs; logic [7:0] cyc;} row_t;
	logic              clk = 1'b0;
	logic              nrst = 1'b0;
	logic              psel, penable, pwrite, pready, pslverr, e;
	logic              busy, disp, curs, blink, width, vgen;
	logic [1:0]        fmt;
	logic [APB_AW-1:0] paddr;
	logic [APB_DW-1:0] pwdata, prdata, r;
	int                n_fail = 0;
	int                check_count = 0;
	int                n;
	row_t              rows [12] = '{
		'{8'h0f, 7'h72, 8'd3},
		'{8'h38, 7'h76, 8'd3},
		'{8'h3c, 7'h7a, 8'd3},
		'{8'h34, 7'h7a, 8'd3},
		'{8'h2a, 7'h75, 8'd3},
		'{8'h38, 7'h76, 8'd3},
		'{8'h0a, 7'h26, 8'd3},
		'{8'h00, 7'h26, 8'd0},
		'{8'h01, 7'h26, 8'd165},
		'{8'h02, 7'h26, 8'd3},
		'{8'h07, 7'h26, 8'd3},
		'{8'h1c, 7'h26, 8'd3}};

	always #5 clk = ~clk;

	lcd_instr_decoder #(.INIT_BUSY_CYCLES(INIT)) dut (.SYS_CLK_I(clk), .NRST_I(nrst),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.BUSY_O(busy), .DISPLAY_ON_O(disp), .CURSOR_ON_O(curs), .BLINK_ON_O(blink),
		.LINE_FMT_O(fmt), .BUS_WIDTH_SEL_O(width), .VGEN_O(vgen));

	lcd_host_model host (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr),
		.prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		if (n_fail == 0 && host.n_hang == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Busy must stand exactly c cycles after the completing edge
	task automatic busy_for(input int c);
		#1;
		if (c == 0)
			chk(busy, 1'b0);
		else begin
			chk(busy, 1'b1);
			repeat (c - 1) @(posedge clk);
			#1 chk(busy, 1'b1);
			@(posedge clk);
			#1 chk(busy, 1'b0);
		end
	endtask

	task automatic rd(input logic [APB_AW-1:0] adr);
		host.xfer(1'b0, adr, '0, r, e);
	endtask

	task automatic ins(input logic [7:0] code);
		host.xfer(1'b1, OFS_INSTR, 32'(code), r, e);
		host.wait_idle();
	endtask

	initial begin
		repeat (8) @(posedge clk);
		chk({busy, disp, curs, blink, fmt, width, vgen}, 8'h82);
		nrst <= 1'b1;
		fork
			begin
				n = 0;
				do begin
					@(posedge clk);
					#1 n++;
				end while (busy === 1'b1 && n < 100);
				chk(n, INIT);
			end
			begin
				rd(OFS_STATE);
				chk(r[10:0], 11'h448);
				rd(OFS_INSTR);
				chk(r[7:0], 8'h80);
				host.xfer(1'b1, OFS_INSTR, 32'h0f, r, e);
			end
		join
		chk(disp, 1'b0);
		rd(OFS_DATA);
		chk(r[7:0], SPACE_CODE);
		host.wait_idle();
		foreach (rows[i]) begin
			host.xfer(1'b1, OFS_INSTR, 32'(rows[i].code), r, e);
			busy_for(int'(rows[i].cyc));
			chk({disp, curs, blink, fmt, width, vgen}, rows[i].outs);
		end
		rd(OFS_STATE);
		chk(r[22:16], 7'h01);
		host.xfer(1'b1, OFS_DATA, 32'h33, r, e);
		busy_for(3);
		rd(OFS_STATE);
		chk(r[22:16], 7'h00);
		rd(OFS_INSTR);
		chk(r[7:0], 8'h01);
		ins(8'h04);
		ins(8'hc5);
		rd(OFS_INSTR);
		chk(r[7:0], 8'h45);
		host.xfer(1'b1, OFS_DATA, 32'h41, r, e);
		host.wait_idle();
		rd(OFS_INSTR);
		chk(r[7:0], 8'h44);
		ins(8'hc5);
		rd(OFS_DATA);
		chk(r[7:0], 8'h41);
		host.wait_idle();
		rd(OFS_INSTR);
		chk(r[7:0], 8'h44);
		ins(8'h7f);
		rd(OFS_INSTR);
		chk(r[5:0], 6'h3f);
		chk(r[6:0], 7'h7f);
		host.xfer(1'b1, OFS_DATA, 32'h15, r, e);
		host.wait_idle();
		ins(8'h14);
		rd(OFS_INSTR);
		chk(r[7:0], 8'h7f);
		rd(OFS_DATA);
		chk(r[7:0], 8'h15);
		host.wait_idle();
		ins(8'h80);
		rd(OFS_DATA);
		chk(r[7:0], 8'h33);
		host.wait_idle();
		// Second instruction lands while the first is still executing
		host.xfer(1'b1, OFS_INSTR, 32'h0c, r, e);
		host.xfer(1'b1, OFS_INSTR, 32'h08, r, e);
		host.wait_idle();
		chk(disp, 1'b1);
		// A data read inside the busy time answers zero and keeps the counter
		host.xfer(1'b1, OFS_INSTR, 32'h0c, r, e);
		rd(OFS_DATA);
		chk(r[7:0], 8'h00);
		host.wait_idle();
		rd(OFS_INSTR);
		chk(r[7:0], 8'h7f);
		rd(8'h0c);
		chk(e, 1'b1);
		host.xfer(1'b1, OFS_STATE, 32'h00, r, e);
		chk(e, 1'b1);
		rd(OFS_INSTR);
		chk(e, 1'b0);
		// Reset in mid-run: settings return and the text RAM is blanked again
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1 chk({busy, disp, curs, blink, fmt, width, vgen, pready}, 9'h104);
		@(posedge clk);
		nrst <= 1'b1;
		repeat (INIT - 1) @(posedge clk);
		#1 chk(busy, 1'b1);
		@(posedge clk);
		#1 chk(busy, 1'b0);
		rd(OFS_STATE);
		chk(r[22:0], 23'h48);
		rd(OFS_DATA);
		chk(r[7:0], SPACE_CODE);
		give_verdict();
	end

	initial begin
		#50000;
		n_fail++;
		give_verdict();
	end
endmodule
